// [dos_output_state.sv]
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
// Function
// (R1) 256 slots as eight banks of 32
// (R2) Bank 1-8, slot 1-32 map to index
// (R3) Relay on forces full level
// (R4) Relay off shows held analog level
// (R5) Relay on if any source set it
// (R6) Six sequence, script, keyboard sources tracked
// (R7) Analog level: last write wins
// (R8) Slots hold state until rewritten
// (R9) Bank relay-off clears whole bank at once
// (R10) Bank relay-on sets whole bank at once
// (R11) Bank analog-zero writes zero to bank
// (R12) Bank analog-full writes full to bank
// (R13) Bank analog write carries intermediate levels
// (R14) Bank unchanged restores pre-entry analog levels
// (R15) Fade slot addressed only within 1-32
// (R16) Fade ramps start to target over time
// (R17) Unspecified start uses current slot level
// (R18) Live target ignores start, updates each tick
// (R19) Curve fade starts first value, ends last; no curve mode, only constant and live fades
// (R20) Level quantised to 8 bits, full 255
// (R21) Fade steps linearly per update tick
module dos_output_state #(
  parameter int P_TICK_CYCLES = dos_pkg::TICK_CYCLES,
  parameter int P_TIME_W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [dos_pkg::AW-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [dos_pkg::AW-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic [7:0] i_fader_level,
  output dos_pkg::dos_dmx_t o_dmx
);
  import dos_pkg::*;

  localparam int TW = $clog2(P_TICK_CYCLES);

  typedef enum logic [1:0] {FD_IDLE, FD_RAMP, FD_LIVE} dos_fd_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic addr_ok(input logic [3:0] b, input logic [5:0] s);
    addr_ok = (b >= BANK_MIN) && (b <= BANK_MAX) && (s >= SLOT_MIN) && (s <= SLOT_MAX);
  endfunction : addr_ok

  function automatic logic [7:0] lin_idx(input logic [3:0] b, input logic [5:0] s);
    logic [2:0] bi;
    logic [4:0] si;
    bi = 3'(b - BANK_MIN);
    si = 5'(s - SLOT_MIN);
    lin_idx = {bi, si}; // R2
  endfunction : lin_idx

  function automatic logic [31:0] merge(input logic [31:0] d, input logic [3:0] st);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        m[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = m;
  endfunction : merge

  // ----------------------------------------------------------------
  // State storage
  // ----------------------------------------------------------------
  logic [SLOTS_PER_BANK-1:0] relay_r [NUM_SRC][NUM_BANKS]; // R1 R6
  logic [7:0] ana_r [NUM_SLOTS];
  logic [7:0] prev_r [NUM_SLOTS];

  logic aw_rdy_r, aw_have_r, w_rdy_r, w_have_r, bvalid_r;
  logic [AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r;
  logic ar_rdy_r, rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  logic [31:0] mask_r, fade_addr_r, fade_live_r, fade_ctrl_r;
  logic [P_TIME_W-1:0] fade_time_r;
  logic [7:0] rb_sel_r;
  logic err_r;

  logic [7:0] fdr_s1_r, fdr_s2_r;
  logic [TW-1:0] tick_cnt_r;
  logic tick_r;

  dos_fd_t fd_state_r;
  logic [7:0] fd_idx_r, cur_r, tgt_r, absd_r;
  logic up_r, fd_wr_r;
  logic [P_TIME_W-1:0] dur_r, n_r;
  logic [P_TIME_W:0] err_acc_r;

  logic [7:0] scan_r;
  dos_dmx_t dmx_r;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  logic wr_go;
  logic [31:0] wval;
  dos_cmd_t cmd;
  dos_fade_ctrl_t fctl;
  logic cmd_go, cmd_ok, fctl_go, fade_ok, cmd_refused;
  logic [2:0] cmd_bank;
  logic [7:0] cmd_idx;
  dos_cmd_t faddr;

  always_comb begin
    wr_go = aw_have_r && w_have_r && !bvalid_r;
    wval = merge(wdata_r, wstrb_r);
    cmd = dos_cmd_t'(wval);
    fctl = dos_fade_ctrl_t'(wval);
    faddr = dos_cmd_t'(fade_addr_r);
    cmd_go = wr_go && (awaddr_r == ADDR_CMD);
    cmd_ok = addr_ok(cmd.bank, cmd.slot) && (cmd.src < 3'(NUM_SRC));
    cmd_idx = lin_idx(cmd.bank, cmd.slot);
    cmd_bank = cmd_idx[7:5];
    fctl_go = wr_go && (awaddr_r == ADDR_FADE_CTRL);
    fade_ok = addr_ok(faddr.bank, faddr.slot); // R15
    cmd_refused = (cmd_go && !cmd_ok && cmd.op != OP_ENTRY && cmd.op != OP_NOP)
                  || (fctl_go && fctl.mode != FM_OFF && !fade_ok);
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_rdy_r <= 1'b1;
      aw_have_r <= 1'b0;
      awaddr_r <= '0;
      w_rdy_r <= 1'b1;
      w_have_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && aw_rdy_r) begin
        aw_rdy_r <= 1'b0;
        aw_have_r <= 1'b1;
        awaddr_r <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && w_rdy_r) begin
        w_rdy_r <= 1'b0;
        w_have_r <= 1'b1;
        wdata_r <= i_s_axi_wdata;
        wstrb_r <= i_s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        case (awaddr_r)
          ADDR_CMD, ADDR_MASK, ADDR_FADE_ADDR, ADDR_FADE_TIME, ADDR_FADE_LIVE,
          ADDR_FADE_CTRL, ADDR_STATUS, ADDR_RB_SEL: bresp_r <= RESP_OKAY;
          default: bresp_r <= RESP_SLVERR;
        endcase
      end
      if (bvalid_r && i_s_axi_bready) begin
        bvalid_r <= 1'b0;
        aw_rdy_r <= 1'b1;
        w_rdy_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mask_r <= '0;
      fade_addr_r <= '0;
      fade_time_r <= '0;
      fade_live_r <= '0;
      fade_ctrl_r <= '0;
      rb_sel_r <= '0;
    end else if (wr_go) begin
      case (awaddr_r)
        ADDR_MASK: mask_r <= wval;
        ADDR_FADE_ADDR: fade_addr_r <= wval;
        ADDR_FADE_TIME: fade_time_r <= wval[P_TIME_W-1:0];
        ADDR_FADE_LIVE: fade_live_r <= wval;
        ADDR_FADE_CTRL: fade_ctrl_r <= wval;
        ADDR_RB_SEL: rb_sel_r <= wval[7:0];
        default: ;
      endcase
    end
  end

  // Sticky refusal flag; a new refusal beats the clear
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      err_r <= 1'b0;
    end else if (cmd_refused) begin
      err_r <= 1'b1;
    end else if (wr_go && awaddr_r == ADDR_STATUS && wval[ST_ERR]) begin
      err_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Relay state per source
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int s = 0; s < NUM_SRC; s++) begin
        for (int b = 0; b < NUM_BANKS; b++) begin
          relay_r[s][b] <= '0;
        end
      end
    end else if (cmd_go && cmd_ok) begin
      // Untouched slots keep their state across entries R8
      case (cmd.op)
        OP_RELAY_SLOT: relay_r[cmd.src][cmd_bank][cmd_idx[4:0]] <= cmd.level[0];
        OP_RELAY_OFF: relay_r[cmd.src][cmd_bank] <= '0; // R9
        OP_RELAY_ON: relay_r[cmd.src][cmd_bank] <= '1; // R10
        OP_RELAY_MASK: relay_r[cmd.src][cmd_bank] <= mask_r;
        default: ;
      endcase
    end
  end

  function automatic logic relay_any(input logic [7:0] idx);
    logic r;
    r = 1'b0;
    for (int s = 0; s < NUM_SRC; s++) begin
      r = r | relay_r[s][idx[7:5]][idx[4:0]]; // R5
    end
    relay_any = r;
  endfunction : relay_any

  // ----------------------------------------------------------------
  // Analog levels
  // ----------------------------------------------------------------
  // Fade update first, command second: a command in the same cycle is the later write
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        ana_r[i] <= LVL_ZERO;
      end
    end else begin
      if (fd_wr_r) begin
        ana_r[fd_idx_r] <= cur_r; // R7
      end
      if (cmd_go && cmd_ok) begin
        for (int k = 0; k < SLOTS_PER_BANK; k++) begin
          case (cmd.op)
            OP_ANA_ZERO: ana_r[{cmd_bank, 5'(k)}] <= LVL_ZERO; // R11
            OP_ANA_FULL: ana_r[{cmd_bank, 5'(k)}] <= LVL_FULL; // R12
            OP_ANA_UNCHG: ana_r[{cmd_bank, 5'(k)}] <= prev_r[{cmd_bank, 5'(k)}]; // R14
            OP_ANA_LVL: if (mask_r[k]) ana_r[{cmd_bank, 5'(k)}] <= cmd.level; // R13
            default: ;
          endcase
        end
        if (cmd.op == OP_ANA_SLOT) begin
          ana_r[cmd_idx] <= cmd.level; // R7 R13
        end
      end
    end
  end

  // Snapshot taken at the start of each entry
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        prev_r[i] <= LVL_ZERO;
      end
    end else if (cmd_go && cmd.op == OP_ENTRY) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        prev_r[i] <= ana_r[i]; // R14
      end
    end
  end

  // ----------------------------------------------------------------
  // Fader pin synchroniser and update tick
  // ----------------------------------------------------------------
  // Multi-bit pin: a level that moves during sampling may read one tick late
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fdr_s1_r <= '0;
      fdr_s2_r <= '0;
    end else begin
      fdr_s1_r <= i_fader_level;
      fdr_s2_r <= fdr_s1_r;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == TW'(P_TICK_CYCLES - 1));
      if (tick_cnt_r == TW'(P_TICK_CYCLES - 1)) begin
        tick_cnt_r <= '0;
      end else begin
        tick_cnt_r <= tick_cnt_r + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Single-slot fade engine
  // ----------------------------------------------------------------
  logic [7:0] f_start;
  dos_fade_ctrl_t fctl_cur;
  always_comb begin
    fctl_cur = dos_fade_ctrl_t'(fade_ctrl_r);
    f_start = fctl.from_unspec ? ana_r[lin_idx(faddr.bank, faddr.slot)] : fctl.from; // R17
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fd_state_r <= FD_IDLE;
      fd_idx_r <= '0;
      cur_r <= '0;
      tgt_r <= '0;
      absd_r <= '0;
      up_r <= 1'b0;
      dur_r <= '0;
      n_r <= '0;
      err_acc_r <= '0;
      fd_wr_r <= 1'b0;
    end else begin
      fd_wr_r <= 1'b0;
      if (fctl_go) begin
        if (fctl.mode == FM_OFF || !fade_ok) begin
          fd_state_r <= FD_IDLE;
        end else if (fctl.mode == FM_CONST) begin
          fd_idx_r <= lin_idx(faddr.bank, faddr.slot);
          tgt_r <= fctl.to;
          up_r <= fctl.to >= f_start;
          absd_r <= (fctl.to >= f_start) ? fctl.to - f_start : f_start - fctl.to;
          dur_r <= fade_time_r;
          n_r <= '0;
          err_acc_r <= '0;
          fd_wr_r <= 1'b1;
          if (fade_time_r == '0) begin
            cur_r <= fctl.to;
            fd_state_r <= FD_IDLE;
          end else begin
            cur_r <= f_start; // R16
            fd_state_r <= FD_RAMP;
          end
        end else begin
          fd_idx_r <= lin_idx(faddr.bank, faddr.slot);
          fd_state_r <= FD_LIVE; // R18
        end
      end else begin
        case (fd_state_r)
          FD_RAMP: begin
            if (tick_r) begin
              if (n_r + 1'b1 >= dur_r) begin
                cur_r <= tgt_r; // R16
                fd_wr_r <= 1'b1;
                fd_state_r <= FD_IDLE;
              end else begin
                n_r <= n_r + 1'b1;
                err_acc_r <= err_acc_r + (P_TIME_W+1)'(absd_r); // R21
              end
            end else if (err_acc_r >= {1'b0, dur_r}) begin
              // One level step per clock; ticks are far longer than 255 clocks
              err_acc_r <= err_acc_r - {1'b0, dur_r};
              cur_r <= up_r ? cur_r + 8'h01 : cur_r - 8'h01; // R21
              fd_wr_r <= 1'b1;
            end
          end
          FD_LIVE: begin
            if (tick_r) begin
              cur_r <= (fctl_cur.mode == FM_LIVE_PIN) ? fdr_s2_r : fade_live_r[7:0]; // R18
              fd_wr_r <= 1'b1;
            end
          end
          default: fd_state_r <= FD_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ar_rdy_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      if (i_s_axi_arvalid && ar_rdy_r) begin
        ar_rdy_r <= 1'b0;
        rvalid_r <= 1'b1;
        rresp_r <= RESP_OKAY;
        case (i_s_axi_araddr)
          ADDR_CMD: rdata_r <= '0;
          ADDR_MASK: rdata_r <= mask_r;
          ADDR_FADE_ADDR: rdata_r <= fade_addr_r;
          ADDR_FADE_TIME: rdata_r <= 32'(fade_time_r);
          ADDR_FADE_LIVE: rdata_r <= fade_live_r;
          ADDR_FADE_CTRL: rdata_r <= fade_ctrl_r;
          ADDR_STATUS: rdata_r <= {30'h0, err_r, fd_state_r != FD_IDLE};
          ADDR_RB_SEL: rdata_r <= {24'h0, rb_sel_r};
          ADDR_RB_DATA: rdata_r <= {23'h0, relay_any(rb_sel_r), ana_r[rb_sel_r]};
          default: begin
            rdata_r <= '0;
            rresp_r <= RESP_SLVERR;
          end
        endcase
      end
      if (rvalid_r && i_s_axi_rready) begin
        rvalid_r <= 1'b0;
        ar_rdy_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Slot output scan
  // ----------------------------------------------------------------
  // One slot per clock; a full frame of 256 takes 256 clocks
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scan_r <= '0;
      dmx_r <= '0;
    end else begin
      scan_r <= scan_r + 8'h01;
      dmx_r.chan <= {1'b0, scan_r} + 9'h001; // R2
      dmx_r.level <= relay_any(scan_r) ? LVL_FULL : ana_r[scan_r]; // R3 R4 R20
    end
  end

  assign o_s_axi_awready = aw_rdy_r;
  assign o_s_axi_wready = w_rdy_r;
  assign o_s_axi_bvalid = bvalid_r;
  assign o_s_axi_bresp = bresp_r;
  assign o_s_axi_arready = ar_rdy_r;
  assign o_s_axi_rvalid = rvalid_r;
  assign o_s_axi_rdata = rdata_r;
  assign o_s_axi_rresp = rresp_r;
  assign o_dmx = dmx_r;

endmodule : dos_output_state

// [dos_pkg.sv]
package dos_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_BANKS = 8;
  localparam int SLOTS_PER_BANK = 32;
  localparam int NUM_SLOTS = 256;
  localparam int NUM_SRC = 6;
  localparam logic [3:0] BANK_MIN = 4'h1;
  localparam logic [3:0] BANK_MAX = 4'h8;
  localparam logic [5:0] SLOT_MIN = 6'h01;
  localparam logic [5:0] SLOT_MAX = 6'h20;
  localparam logic [7:0] LVL_ZERO = 8'h00;
  localparam logic [7:0] LVL_FULL = 8'hff;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam int AW = 8;
  localparam logic [AW-1:0] ADDR_CMD = 8'h00;
  localparam logic [AW-1:0] ADDR_MASK = 8'h04;
  localparam logic [AW-1:0] ADDR_FADE_ADDR = 8'h08;
  localparam logic [AW-1:0] ADDR_FADE_TIME = 8'h0c;
  localparam logic [AW-1:0] ADDR_FADE_LIVE = 8'h10;
  localparam logic [AW-1:0] ADDR_FADE_CTRL = 8'h14;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h18;
  localparam logic [AW-1:0] ADDR_RB_SEL = 8'h1c;
  localparam logic [AW-1:0] ADDR_RB_DATA = 8'h20;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_RELAY_SLOT = 4'h1;
  localparam logic [3:0] OP_RELAY_OFF = 4'h2;
  localparam logic [3:0] OP_RELAY_ON = 4'h3;
  localparam logic [3:0] OP_RELAY_MASK = 4'h4;
  localparam logic [3:0] OP_ANA_SLOT = 4'h5;
  localparam logic [3:0] OP_ANA_ZERO = 4'h6;
  localparam logic [3:0] OP_ANA_FULL = 4'h7;
  localparam logic [3:0] OP_ANA_UNCHG = 4'h8;
  localparam logic [3:0] OP_ANA_LVL = 4'h9;
  localparam logic [3:0] OP_ENTRY = 4'ha;

  // Fade modes
  localparam logic [1:0] FM_OFF = 2'h0;
  localparam logic [1:0] FM_CONST = 2'h1;
  localparam logic [1:0] FM_LIVE_REG = 2'h2;
  localparam logic [1:0] FM_LIVE_PIN = 2'h3;

  // Status bits
  localparam int ST_FADE = 0;
  localparam int ST_ERR = 1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int UPDATE_TICK_NS = 1000000;
  localparam int TICK_CYCLES = UPDATE_TICK_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] op;
    logic rsv_a;
    logic [2:0] src;
    logic [3:0] rsv_b;
    logic [3:0] bank;
    logic [1:0] rsv_c;
    logic [5:0] slot;
    logic [7:0] level;
  } dos_cmd_t;

  typedef struct packed {
    logic [5:0] rsv_a;
    logic [1:0] mode;
    logic [7:0] to;
    logic [7:0] from;
    logic [6:0] rsv_b;
    logic from_unspec;
  } dos_fade_ctrl_t;

  typedef struct packed {
    logic [8:0] chan;
    logic [7:0] level;
  } dos_dmx_t;

endpackage : dos_pkg

// [dos_dmx_rx.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Effect device side of the slot scan
// ----------------------------------------
module dos_dmx_rx (
  input wire logic i_clk,
  input wire dos_pkg::dos_dmx_t i_dmx
);
  import dos_pkg::*;
  // Keeps the last level seen per channel, as a receiving fixture does
  logic [7:0] lvl_r [0:256];
  always_ff @(posedge i_clk) begin
    lvl_r[i_dmx.chan] <= i_dmx.level;
  end
endmodule : dos_dmx_rx

// [dos_output_state_sva.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module dos_output_state_sva (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [dos_pkg::AW-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic [1:0] o_s_axi_bresp,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [dos_pkg::AW-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic [1:0] o_s_axi_rresp,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic [7:0] i_fader_level,
  input wire dos_pkg::dos_dmx_t o_dmx
);
  import dos_pkg::*;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  sequence s_w_take;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  sequence s_b_done;
    o_s_axi_bvalid && i_s_axi_bready;
  endsequence
  sequence s_r_take;
    i_s_axi_arvalid && o_s_axi_arready;
  endsequence
  // Chan 0 only during reset, so it is no step
  a_chan_step: assert property (
    (o_dmx.chan != 9'h000) |=>
    o_dmx.chan == (($past(o_dmx.chan) == 9'h100) ? 9'h001 : $past(o_dmx.chan) + 9'h001))
    else $error("slot scan out of order");
  a_chan_range: assert property (o_dmx.chan <= 9'h100)
    else $error("slot scan beyond last slot");
  // Both halves are latched first, so the answer stands two cycles after the take
  a_b_answer: assert property (s_w_take |=> !o_s_axi_awready ##1 o_s_axi_bvalid)
    else $error("write response late");
  a_b_busy: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write taken while busy");
  a_b_release: assert property (s_b_done |=> !o_s_axi_bvalid && o_s_axi_awready && o_s_axi_wready)
    else $error("write channel not released");
  a_r_answer: assert property (s_r_take |=> o_s_axi_rvalid && !o_s_axi_arready)
    else $error("read response late");
  a_r_release: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid && o_s_axi_arready)
    else $error("read channel not released");
  a_r_err_zero: assert property (o_s_axi_rvalid && (o_s_axi_rresp == RESP_SLVERR) |-> o_s_axi_rdata == 32'h0)
    else $error("refused read carries data");
endmodule : dos_output_state_sva
bind dos_output_state dos_output_state_sva u_sva (.*);

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import dos_pkg::*;
  // Tick long enough for a full ramp to finish stepping
  localparam int TK = 400;
  logic i_clk = 1'b0, i_rst_b = 1'b0;
  logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00, i_fader_level = 8'h00;
  logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata;
  logic [3:0] i_s_axi_wstrb = 4'hf;
  logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
  logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
  dos_dmx_t o_dmx;
  int failures = 0, compares = 0, cyc = 0, s;
  dos_output_state #(.P_TICK_CYCLES(TK)) u_dut (.*);
  dos_dmx_rx u_rx (.i_clk(i_clk), .i_dmx(o_dmx));
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge i_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
    end while (o_s_axi_bvalid !== 1'b1);
    i_s_axi_bready <= 1'b0;
    chk("bresp", er, o_s_axi_bresp);
  endtask : wr
  task rdc(input string n, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge i_clk);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
    end while (o_s_axi_rvalid !== 1'b1);
    i_s_axi_rready <= 1'b0;
    chk(n, e, o_s_axi_rdata);
    chk("rresp", er, o_s_axi_rresp);
  endtask : rdc
  task slot(input logic [7:0] i, input logic [31:0] e);
    wr(ADDR_RB_SEL, {24'h0, i}, RESP_OKAY);
    rdc("slot", ADDR_RB_DATA, e, RESP_OKAY);
  endtask : slot
  task cmd(input logic [3:0] op, input logic [2:0] sr, input logic [3:0] b, input logic [5:0] sl, input logic [7:0] l);
    dos_cmd_t c;
    c = '0;
    c.op = op;
    c.src = sr;
    c.bank = b;
    c.slot = sl;
    c.level = l;
    wr(ADDR_CMD, c, RESP_OKAY);
  endtask : cmd
  task fade(input logic [1:0] m, input logic [7:0] t, input logic [7:0] f, input logic u);
    dos_fade_ctrl_t c;
    c = '0;
    c.mode = m;
    c.to = t;
    c.from = f;
    c.from_unspec = u;
    wr(ADDR_FADE_CTRL, c, RESP_OKAY);
  endtask : fade
  task dmx(input logic [8:0] ch, input logic [7:0] e);
    repeat (260) @(posedge i_clk);
    chk("dmx", {24'h0, e}, {24'h0, u_rx.lvl_r[ch]});
  endtask : dmx
  task err_clr;
    rdc("status", ADDR_STATUS, 32'h2, RESP_OKAY);
    wr(ADDR_STATUS, 32'h2, RESP_OKAY);
  endtask : err_clr
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      conclude();
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rdc("cmd", ADDR_CMD, 32'h0, RESP_OKAY);
    rdc("unmapped", 8'h24, 32'h0, RESP_SLVERR);
    wr(8'h24, 32'h1, RESP_SLVERR);
    slot(8'h58, 32'h0);
    cmd(OP_ANA_SLOT, 3'h0, 4'h3, 6'h19, 8'h40);
    slot(8'h58, 32'h40);
    dmx(9'h059, 8'h40);
    for (s = 0; s < 6; s++) begin
      cmd(OP_RELAY_SLOT, s[2:0], 4'h3, 6'h19, 8'h01);
      slot(8'h58, 32'h140);
      cmd(OP_RELAY_SLOT, s[2:0], 4'h3, 6'h19, 8'h00);
      slot(8'h58, 32'h040);
    end
    cmd(OP_RELAY_SLOT, 3'h2, 4'h3, 6'h19, 8'h01);
    cmd(OP_RELAY_SLOT, 3'h4, 4'h3, 6'h19, 8'h00);
    slot(8'h58, 32'h140);
    dmx(9'h059, 8'hff);
    cmd(OP_RELAY_SLOT, 3'h2, 4'h3, 6'h19, 8'h00);
    dmx(9'h059, 8'h40);
    cmd(OP_RELAY_SLOT, 3'h6, 4'h3, 6'h19, 8'h01);
    slot(8'h58, 32'h040);
    err_clr();
    cmd(OP_ANA_SLOT, 3'h0, 4'h0, 6'h01, 8'h99);
    cmd(OP_ANA_SLOT, 3'h0, 4'h1, 6'h21, 8'h99);
    cmd(OP_ANA_SLOT, 3'h0, 4'h9, 6'h01, 8'h99);
    slot(8'h20, 32'h0);
    slot(8'h00, 32'h0);
    err_clr();
    cmd(OP_ANA_SLOT, 3'h0, 4'h3, 6'h19, 8'h10);
    cmd(OP_ANA_SLOT, 3'h5, 4'h3, 6'h19, 8'h20);
    slot(8'h58, 32'h20);
    cmd(OP_RELAY_ON, 3'h1, 4'h2, 6'h01, 8'h00);
    slot(8'h20, 32'h100);
    slot(8'h3f, 32'h100);
    slot(8'h40, 32'h0);
    cmd(OP_RELAY_OFF, 3'h1, 4'h2, 6'h01, 8'h00);
    slot(8'h3f, 32'h0);
    cmd(OP_ENTRY, 3'h0, 4'h0, 6'h00, 8'h00);
    cmd(OP_ANA_FULL, 3'h0, 4'h3, 6'h01, 8'h00);
    slot(8'h40, 32'hff);
    dmx(9'h059, 8'hff);
    cmd(OP_ANA_ZERO, 3'h0, 4'h3, 6'h01, 8'h00);
    slot(8'h58, 32'h0);
    cmd(OP_ANA_UNCHG, 3'h0, 4'h3, 6'h01, 8'h00);
    slot(8'h58, 32'h20);
    slot(8'h40, 32'h0);
    wr(ADDR_MASK, 32'h1, RESP_OKAY);
    cmd(OP_ANA_LVL, 3'h0, 4'h3, 6'h01, 8'h33);
    slot(8'h40, 32'h33);
    slot(8'h41, 32'h0);
    wr(ADDR_FADE_ADDR, 32'h00010100, RESP_OKAY);
    wr(ADDR_FADE_TIME, 32'h2, RESP_OKAY);
    fade(FM_CONST, 8'h80, 8'h00, 1'b0);
    rdc("status", ADDR_STATUS, 32'h1, RESP_OKAY);
    repeat (3 * TK) @(posedge i_clk);
    rdc("status", ADDR_STATUS, 32'h0, RESP_OKAY);
    slot(8'h00, 32'h80);
    fade(FM_CONST, 8'h80, 8'hff, 1'b1);
    slot(8'h00, 32'h80);
    repeat (3 * TK) @(posedge i_clk);
    wr(ADDR_FADE_LIVE, 32'h55, RESP_OKAY);
    fade(FM_LIVE_REG, 8'h11, 8'h11, 1'b0);
    repeat (TK + 100) @(posedge i_clk);
    slot(8'h00, 32'h55);
    wr(ADDR_FADE_LIVE, 32'h66, RESP_OKAY);
    repeat (TK + 100) @(posedge i_clk);
    slot(8'h00, 32'h66);
    i_fader_level <= 8'h77;
    fade(FM_LIVE_PIN, 8'h11, 8'h11, 1'b0);
    repeat (TK + 100) @(posedge i_clk);
    slot(8'h00, 32'h77);
    fade(FM_OFF, 8'h00, 8'h00, 1'b0);
    rdc("status", ADDR_STATUS, 32'h0, RESP_OKAY);
    conclude();
  end
endmodule : tb_top
